//--- inc/spi_fifo_pkg.sv
// Purpose: constants shared by the serial port FIFO, status and data port block
// Assumes: register offsets are byte addresses on the block's register port
// Notes:   status field positions and the threshold, select and data reset values live here

package spi_fifo_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [31:0] THRESHOLD_STATUS_ADDR = 32'h5000_1214;
	localparam logic [31:0] FIFO_STATUS_ADDR = 32'h5000_1218;
	localparam logic [31:0] RX_DATA_PORT_ADDR = 32'h5000_121C;
	localparam logic [31:0] TX_DATA_PORT_ADDR = 32'h5000_1220;
	localparam logic [31:0] SELECT_CONFIG_ADDR = 32'h5000_1224;
	localparam logic [31:0] HIGH_HALF_DATA_ADDR = 32'h5000_1228;
	localparam logic [31:0] SHIFT_PRELOAD_LOW_ADDR = 32'h5000_122C;
	localparam logic [31:0] SHIFT_PRELOAD_HIGH_ADDR = 32'h5000_1230;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_RX_THRESH = 1;
	localparam int BIT_TX_THRESH = 0;
	localparam int BIT_XFER_ACTIVE = 15;
	localparam int BIT_RX_OVERFLOW = 14;
	localparam int BIT_TX_FULL = 13;
	localparam int BIT_RX_EMPTY = 12;
	localparam int TX_LEVEL_LSB = 6;
	localparam int RX_LEVEL_LSB = 0;

	// ------------------------------------------------------------
	// reset values and sizes
	// ------------------------------------------------------------
	localparam logic RX_THRESH_RST = 1'h0;
	localparam logic TX_THRESH_RST = 1'h1;
	localparam logic [2:0] SELECT_RST = 3'h0;
	localparam logic [15:0] HIGH_HALF_RST = 16'h0000;
	localparam logic [15:0] READ_DATA_RST = 16'h0000;
	localparam int FIFO_BYTES = 4;

	// ------------------------------------------------------------
	// select field codes
	// ------------------------------------------------------------
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_PIN_A = 3'h1;
	localparam logic [2:0] SEL_PIN_B = 3'h2;
	localparam logic [2:0] SEL_GPIO = 3'h4;

	// link engine states
	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_MASTER = 2'b01,
		LINK_SLAVE = 2'b10
	} link_state_e;

endpackage : spi_fifo_pkg

//--- hw/spi_fifo_port.sv
// Purpose: FIFO, status, data port and select logic of a serial port controller
// Assumes: clock mode 0, msb first; link pins sampled by two flip-flops
// Notes:   register reads answer one cycle after the read strobe
//
// What this block does
// - rx threshold bit high while rx level at least threshold plus one
// - tx threshold bit high while tx level at or below threshold; resets one
// - bit 15 of fifo status shows a master transfer in progress
// - word arriving on full rx fifo is dropped, sticky overflow flag raised
// - tx full in bit 13, rx empty in bit 12; empty resets one
// - tx byte level in bits 11:6, rx byte level in bits 5:0
// - reading rx data port pops one word, returns low sixteen bits
// - writing tx data port pushes a word; reading it returns zero
// - select field picks none, pin a, pin b or gpio select in master
// - upper sixteen bits travel through the high half data register
// - low preload write loads low half of the transmit shift buffer
// - high preload write loads high half of the transmit shift buffer
// - thresholds are four bit fields compared against byte levels
// - fifo reset control holds both fifos empty while set

module spi_fifo_port #(
	parameter int DEPTH = spi_fifo_pkg::FIFO_BYTES
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// register port
	input wire logic [31:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	// controller settings
	input wire logic i_spi_en,
	input wire logic i_tx_en,
	input wire logic i_rx_en,
	input wire logic i_slave_mode,
	input wire logic i_fifo_reset,
	input wire logic [4:0] i_word_len,
	input wire logic [6:0] i_clk_div,
	input wire logic [3:0] i_rx_threshold,
	input wire logic [3:0] i_tx_threshold,
	// link pins
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_sdi,
	output logic o_sclk,
	output logic o_sclk_oe,
	output logic o_sdo,
	output logic o_select_pin_a_n,
	output logic o_select_pin_b_n,
	output logic o_select_gpio_n,
	// status to the controller
	output logic o_rx_overflow_flag,
	output logic o_rx_threshold_hit,
	output logic o_tx_threshold_hit
);

	localparam int PW = $clog2(DEPTH);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// bytes taken by one word of the configured length
	function automatic logic [2:0] word_bytes(input logic [4:0] wl);
		if (wl < 5'h08) begin
			return 3'h1;
		end else if (wl < 5'h10) begin
			return 3'h2;
		end else if (wl < 5'h18) begin
			return 3'h3;
		end
		return 3'h4;
	endfunction : word_bytes

	// byte level of a fifo holding cnt words
	function automatic logic [5:0] byte_level(input logic [PW:0] cnt, input logic [2:0] bpw);
		return 6'({{(5 - PW){1'b0}}, cnt} * {3'h0, bpw});
	endfunction : byte_level

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q, cs_s1_q, cs_s2_q, sdi_s1_q, sdi_s2_q;

	// first stage feeds only the second; third stage finds edges
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			{sclk_s1_q, sclk_s2_q, sclk_s3_q} <= 3'h0;
			{cs_s1_q, cs_s2_q} <= 2'h3;
			{sdi_s1_q, sdi_s2_q} <= 2'h0;
		end else begin
			{sclk_s1_q, sclk_s2_q, sclk_s3_q} <= {i_sclk, sclk_s1_q, sclk_s2_q};
			{cs_s1_q, cs_s2_q} <= {i_cs_n, cs_s1_q};
			{sdi_s1_q, sdi_s2_q} <= {i_sdi, sdi_s1_q};
		end
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [31:0] tx_mem_q [DEPTH];
	logic [31:0] tx_mem_d [DEPTH];
	logic [31:0] rx_mem_q [DEPTH];
	logic [31:0] rx_mem_d [DEPTH];
	logic [PW-1:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d, rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
	logic [PW:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
	logic [15:0] tx_hi_q, tx_hi_d, rx_hi_q, rx_hi_d, rdata_q, rdata_d;
	logic [31:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
	logic [2:0] sel_q, sel_d;
	logic [5:0] bit_q, bit_d;
	logic [6:0] div_q, div_d;
	spi_fifo_pkg::link_state_e state_q, state_d;
	logic ovf_q, ovf_d, rx_hit_q, rx_hit_d, tx_hit_q, tx_hit_d;
	logic sclk_q, sclk_d, sclk_oe_q, sclk_oe_d, sdo_q, sdo_d;
	logic sel_a_q, sel_a_d, sel_b_q, sel_b_d, sel_g_q, sel_g_d;

	// decoded strobes and derived levels
	logic wr_tx, rd_rx, rd_fstat, tx_full, rx_full, tx_pop, rx_push;
	logic [2:0] bpw, cap;
	logic [5:0] tx_lvl, rx_lvl, n_bits;
	logic [4:0] msb_next;

	assign wr_tx = i_reg_wr && (i_reg_addr == spi_fifo_pkg::TX_DATA_PORT_ADDR);
	assign rd_rx = i_reg_rd && (i_reg_addr == spi_fifo_pkg::RX_DATA_PORT_ADDR);
	assign rd_fstat = i_reg_rd && (i_reg_addr == spi_fifo_pkg::FIFO_STATUS_ADDR);
	assign bpw = word_bytes(i_word_len);
	// capacity in words: a three byte word still fills the four byte store
	assign cap = (bpw == 3'h1) ? 3'h4 : ((bpw == 3'h2) ? 3'h2 : 3'h1);
	assign tx_full = ({{(2 - PW){1'b0}}, tx_cnt_q} >= cap);
	assign rx_full = ({{(2 - PW){1'b0}}, rx_cnt_q} >= cap);
	assign tx_lvl = byte_level(tx_cnt_q, bpw);
	assign rx_lvl = byte_level(rx_cnt_q, bpw);
	assign n_bits = {1'b0, i_word_len} + 6'h01;
	assign msb_next = i_word_len - 5'h01;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		tx_mem_d = tx_mem_q;
		rx_mem_d = rx_mem_q;
		{tx_wp_d, tx_rp_d, rx_wp_d, rx_rp_d} = {tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q};
		{tx_hi_d, rx_hi_d, sel_d} = {tx_hi_q, rx_hi_q, sel_q};
		{tx_sh_d, rx_sh_d, bit_d, div_d} = {tx_sh_q, rx_sh_q, bit_q, div_q};
		{state_d, sclk_d, sdo_d, ovf_d} = {state_q, sclk_q, sdo_q, ovf_q};
		rdata_d = spi_fifo_pkg::READ_DATA_RST;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		// link engine
		case (state_q)
			spi_fifo_pkg::LINK_IDLE: begin
				sclk_d = 1'b0;
				if (i_spi_en && !i_slave_mode && i_tx_en && tx_cnt_q != '0) begin
					tx_pop = 1'b1;
					tx_sh_d = tx_mem_q[tx_rp_q];
					sdo_d = tx_mem_q[tx_rp_q][i_word_len];
					{bit_d, div_d} = 13'h0000;
					state_d = spi_fifo_pkg::LINK_MASTER;
				end else if (i_spi_en && i_slave_mode && !cs_s2_q) begin
					// preloaded buffer goes out unless the fifo holds a word
					if (i_tx_en && tx_cnt_q != '0) begin
						tx_pop = 1'b1;
						tx_sh_d = tx_mem_q[tx_rp_q];
					end
					bit_d = 6'h00;
					state_d = spi_fifo_pkg::LINK_SLAVE;
				end
			end
			spi_fifo_pkg::LINK_MASTER: begin
				div_d = div_q + 7'h01;
				if (div_q == i_clk_div) begin
					div_d = 7'h00;
					sclk_d = !sclk_q;
					if (!sclk_q) begin
						rx_sh_d = {rx_sh_q[30:0], sdi_s2_q};
						bit_d = bit_q + 6'h01;
					end else if (bit_q == n_bits) begin
						rx_push = i_rx_en;
						state_d = spi_fifo_pkg::LINK_IDLE;
					end else begin
						tx_sh_d = {tx_sh_q[30:0], 1'b0};
						sdo_d = tx_sh_q[msb_next];
					end
				end
			end
			spi_fifo_pkg::LINK_SLAVE: begin
				if (cs_s2_q) begin
					// a partial word is dropped when select goes away
					state_d = spi_fifo_pkg::LINK_IDLE;
				end else if (sclk_s2_q && !sclk_s3_q) begin
					rx_sh_d = {rx_sh_q[30:0], sdi_s2_q};
					bit_d = bit_q + 6'h01;
					if (bit_q + 6'h01 == n_bits) begin
						rx_push = i_rx_en;
						bit_d = 6'h00;
						if (i_tx_en && tx_cnt_q != '0) begin
							tx_pop = 1'b1;
							tx_sh_d = tx_mem_q[tx_rp_q];
						end
					end
				end else if (!sclk_s2_q && sclk_s3_q) begin
					if (bit_q == 6'h00) begin
						sdo_d = tx_sh_q[i_word_len];
					end else begin
						tx_sh_d = {tx_sh_q[30:0], 1'b0};
						sdo_d = tx_sh_q[msb_next];
					end
				end else if (bit_q == 6'h00) begin
					sdo_d = tx_sh_q[i_word_len];
				end
			end
			default: begin
				state_d = spi_fifo_pkg::LINK_IDLE;
			end
		endcase
		// low preload straight into the shift buffer
		if (i_reg_wr && i_reg_addr == spi_fifo_pkg::SHIFT_PRELOAD_LOW_ADDR) begin
			tx_sh_d[15:0] = i_reg_wdata;
		end
		// high preload straight into the shift buffer
		if (i_reg_wr && i_reg_addr == spi_fifo_pkg::SHIFT_PRELOAD_HIGH_ADDR) begin
			tx_sh_d[31:16] = i_reg_wdata;
		end
		// high half staged ahead of the tx port write
		if (i_reg_wr && i_reg_addr == spi_fifo_pkg::HIGH_HALF_DATA_ADDR) begin
			tx_hi_d = i_reg_wdata;
		end
		if (i_reg_wr && i_reg_addr == spi_fifo_pkg::SELECT_CONFIG_ADDR) begin
			sel_d = i_reg_wdata[2:0];
		end
		// join halves on push; writes on a full fifo are dropped
		if (wr_tx && !tx_full) begin
			tx_mem_d[tx_wp_q] = {tx_hi_q, i_reg_wdata};
			tx_wp_d = tx_wp_q + 1'b1;
		end
		if (tx_pop) begin
			tx_rp_d = tx_rp_q + 1'b1;
		end
		tx_cnt_d = tx_cnt_q + {{PW{1'b0}}, wr_tx && !tx_full} - {{PW{1'b0}}, tx_pop};
		// received word dropped on full fifo, sticky flag
		if (rx_push && rx_full) begin
			ovf_d = 1'b1;
		end else if (rx_push) begin
			rx_mem_d[rx_wp_q] = rx_sh_d & ~(32'hFFFF_FFFE << i_word_len); // incl. last bit
			rx_wp_d = rx_wp_q + 1'b1;
		end
		// pop returns low half; high half latched for later read
		if (rd_rx && rx_cnt_q != '0) begin
			rx_rp_d = rx_rp_q + 1'b1;
			rx_hi_d = rx_mem_q[rx_rp_q][31:16];
		end
		rx_cnt_d = rx_cnt_q + {{PW{1'b0}}, rx_push && !rx_full}
			- {{PW{1'b0}}, rd_rx && rx_cnt_q != '0};
		// fifo reset empties both fifos and clears the overflow flag
		if (i_fifo_reset) begin
			{tx_wp_d, tx_rp_d, rx_wp_d, rx_rp_d} = '0;
			{tx_cnt_d, rx_cnt_d} = '0;
			ovf_d = 1'b0;
		end
		rx_hit_d = (rx_lvl >= {2'h0, i_rx_threshold} + 6'h01);
		tx_hit_d = (tx_lvl <= {2'h0, i_tx_threshold});
		// read answers; the tx port and preloads read as zero
		case (i_reg_addr)
			spi_fifo_pkg::THRESHOLD_STATUS_ADDR: begin
				rdata_d[spi_fifo_pkg::BIT_RX_THRESH] = rx_hit_q;
				rdata_d[spi_fifo_pkg::BIT_TX_THRESH] = tx_hit_q;
			end
			spi_fifo_pkg::FIFO_STATUS_ADDR: begin
				// transfer in progress in master mode
				rdata_d[spi_fifo_pkg::BIT_XFER_ACTIVE] = (state_q == spi_fifo_pkg::LINK_MASTER);
				rdata_d[spi_fifo_pkg::BIT_RX_OVERFLOW] = ovf_q;
				rdata_d[spi_fifo_pkg::BIT_TX_FULL] = tx_full;
				rdata_d[spi_fifo_pkg::BIT_RX_EMPTY] = (rx_cnt_q == '0);
				rdata_d[spi_fifo_pkg::TX_LEVEL_LSB +: 6] = tx_lvl;
				rdata_d[spi_fifo_pkg::RX_LEVEL_LSB +: 6] = rx_lvl;
			end
			spi_fifo_pkg::RX_DATA_PORT_ADDR: rdata_d = rx_mem_q[rx_rp_q][15:0];
			spi_fifo_pkg::SELECT_CONFIG_ADDR: rdata_d = {13'h0000, sel_q};
			spi_fifo_pkg::HIGH_HALF_DATA_ADDR: rdata_d = rx_hi_q;
			default: rdata_d = spi_fifo_pkg::READ_DATA_RST;
		endcase
		if (!i_reg_rd || (rd_rx && rx_cnt_q == '0)) begin
			rdata_d = spi_fifo_pkg::READ_DATA_RST;
		end
		// select output follows the field during a master transfer
		sel_a_d = !(state_d == spi_fifo_pkg::LINK_MASTER && sel_q == spi_fifo_pkg::SEL_PIN_A);
		sel_b_d = !(state_d == spi_fifo_pkg::LINK_MASTER && sel_q == spi_fifo_pkg::SEL_PIN_B);
		sel_g_d = !(state_d == spi_fifo_pkg::LINK_MASTER && sel_q == spi_fifo_pkg::SEL_GPIO);
		sclk_oe_d = i_spi_en && !i_slave_mode;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				tx_mem_q[i] <= 32'h0000_0000;
				rx_mem_q[i] <= 32'h0000_0000;
			end
			{tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q} <= '0;
			{tx_cnt_q, rx_cnt_q} <= '0;
			{tx_hi_q, rx_hi_q} <= {spi_fifo_pkg::HIGH_HALF_RST, spi_fifo_pkg::HIGH_HALF_RST};
			rdata_q <= spi_fifo_pkg::READ_DATA_RST;
			{tx_sh_q, rx_sh_q} <= 64'h0;
			sel_q <= spi_fifo_pkg::SELECT_RST;
			{bit_q, div_q} <= 13'h0000;
			state_q <= spi_fifo_pkg::LINK_IDLE;
			ovf_q <= 1'b0;
			rx_hit_q <= spi_fifo_pkg::RX_THRESH_RST;
			tx_hit_q <= spi_fifo_pkg::TX_THRESH_RST;
			{sclk_q, sclk_oe_q, sdo_q} <= 3'h0;
			{sel_a_q, sel_b_q, sel_g_q} <= 3'h7;
		end else begin
			tx_mem_q <= tx_mem_d;
			rx_mem_q <= rx_mem_d;
			{tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q} <= {tx_wp_d, tx_rp_d, rx_wp_d, rx_rp_d};
			{tx_cnt_q, rx_cnt_q} <= {tx_cnt_d, rx_cnt_d};
			{tx_hi_q, rx_hi_q, rdata_q} <= {tx_hi_d, rx_hi_d, rdata_d};
			{tx_sh_q, rx_sh_q} <= {tx_sh_d, rx_sh_d};
			{sel_q, bit_q, div_q} <= {sel_d, bit_d, div_d};
			state_q <= state_d;
			{ovf_q, rx_hit_q, tx_hit_q} <= {ovf_d, rx_hit_d, tx_hit_d};
			{sclk_q, sclk_oe_q, sdo_q} <= {sclk_d, sclk_oe_d, sdo_d};
			{sel_a_q, sel_b_q, sel_g_q} <= {sel_a_d, sel_b_d, sel_g_d};
		end
	end

	assign o_reg_rdata = rdata_q;
	assign o_sclk = sclk_q;
	assign o_sclk_oe = sclk_oe_q;
	assign o_sdo = sdo_q;
	assign o_select_pin_a_n = sel_a_q;
	assign o_select_pin_b_n = sel_b_q;
	assign o_select_gpio_n = sel_g_q;
	assign o_rx_overflow_flag = ovf_q;
	assign o_rx_threshold_hit = rx_hit_q;
	assign o_tx_threshold_hit = tx_hit_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	a_rx_thresh_level: assert property ((rx_lvl >= {2'h0, i_rx_threshold} + 6'h01)
		|=> o_rx_threshold_hit) else $error("rx threshold bit low at level");
	a_tx_thresh_level: assert property ((tx_lvl > {2'h0, i_tx_threshold})
		|=> !o_tx_threshold_hit) else $error("tx threshold bit high above level");
	a_active_report: assert property ((rd_fstat && state_q == spi_fifo_pkg::LINK_MASTER)
		|=> o_reg_rdata[15]) else $error("active bit missing in transfer");
	a_ovf_set_sticky: assert property ((rx_push && rx_full && !i_fifo_reset)
		|=> ovf_q ##1 (ovf_q || $past(i_fifo_reset))) else $error("overflow not held");
	a_full_blocks: assert property ((tx_full && !i_fifo_reset)
		|=> tx_cnt_q <= $past(tx_cnt_q)) else $error("tx grew while full");
	a_rx_pop_count: assert property ((rd_rx && rx_cnt_q != '0 && !rx_push && !i_fifo_reset)
		|=> rx_cnt_q == $past(rx_cnt_q) - 1'b1) else $error("rx pop lost");
	a_tx_push_count: assert property ((wr_tx && !tx_full && !tx_pop && !i_fifo_reset)
		|=> tx_cnt_q == $past(tx_cnt_q) + 1'b1) else $error("tx push lost");
	a_select_pin_a: assert property ((state_d == spi_fifo_pkg::LINK_MASTER
		&& sel_q == spi_fifo_pkg::SEL_PIN_A) |=> !o_select_pin_a_n) else $error("pin a idle");
	a_fifo_reset_empty: assert property (i_fifo_reset |=> (tx_cnt_q == '0 && rx_cnt_q == '0
		&& !ovf_q)) else $error("fifo reset did not empty");
	a_high_join: assert property ((wr_tx && !tx_full && !i_fifo_reset)
		|=> tx_mem_q[$past(tx_wp_q)][31:16] == $past(tx_hi_q)) else $error("high half lost");

	c_overflow: cover property (rx_push && rx_full);
	c_master_word: cover property (state_q == spi_fifo_pkg::LINK_MASTER && rx_push);
	c_slave_word: cover property (state_q == spi_fifo_pkg::LINK_SLAVE && rx_push);
	c_rx_pop: cover property (rd_rx && rx_cnt_q != '0);

endmodule : spi_fifo_port

//--- verif/spi_far_end.sv
// Purpose: behavioural far end of the serial link, slave to the block or master of it
// Assumes: clock mode 0, msb first; tb sets the reply word before each master frame
// Notes:   the data line is inverted on release so a stale bit cannot pass for a real one

module spi_far_end (
	// link driven by the block
	input wire logic i_sclk_m,
	input wire logic i_sdo,
	input wire logic i_sel_n,
	input wire logic [4:0] i_word_len,
	input wire logic [31:0] i_reply,
	// link driven towards the block
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_sdi
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] shr_q;
	logic [31:0] cap_q;
	logic [31:0] got_q[$];

	// ------------------------------------------------------------
	// slave role, answering a master transfer
	// ------------------------------------------------------------
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_sdi = 1'b0;
		shr_q = '0;
		cap_q = '0;
	end
	// selected: reply msb aligned, first bit out before the first rising edge
	always @(negedge i_sel_n) begin
		shr_q = i_reply << (5'd31 - i_word_len);
		o_sdi = shr_q[31];
		cap_q = '0;
	end
	// capture on rising, shift on falling (mode 0)
	always @(posedge i_sclk_m) if (!i_sel_n) cap_q = {cap_q[30:0], i_sdo};
	always @(negedge i_sclk_m) if (!i_sel_n) begin
		shr_q = shr_q << 1;
		o_sdi = shr_q[31];
	end
	// released line shows the inverse of its last value
	always @(posedge i_sel_n) begin
		got_q.push_back(cap_q);
		o_sdi = ~o_sdi;
	end

	// master role: one frame, 200 ns link clock, still outside the frame
	task automatic frame(input logic [31:0] data, input int bits, output logic [31:0] got);
		got = '0;
		o_cs_n = 1'b0;
		o_sdi = data[bits-1];
		#100;
		for (int i = bits - 1; i >= 0; i--) begin
			o_sdi = data[i];
			#100 o_sclk = 1'b1;
			got = {got[30:0], i_sdo};
			#100 o_sclk = 1'b0;
		end
		#100 o_cs_n = 1'b1;
		o_sdi = ~o_sdi;
	endtask : frame
endmodule : spi_far_end

//--- verif/tb.sv
// Purpose: self-checking bench for the fifo, status, data port and select block
// Assumes: register reads answer one cycle after the strobe; mode 0 link
// Notes:   strobes leave one idle cycle between accesses to keep drivers race free

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, rst_n, wr, rd, spi_en, tx_en, rx_en, slave, fifo_rst;
	logic [31:0] addr, reply, got, seed, tmp, exp_w;
	logic [15:0] wdata, rdata, hi;
	logic [4:0] wlen;
	logic [6:0] div;
	logic [3:0] rx_thr, tx_thr;
	logic sclk_in, cs_n_in, sdi_in, sclk_out, sclk_oe, sdo, sel_a_n, sel_b_n, sel_g_n;
	logic ovf, rx_hit, tx_hit;
	logic [2:0] seen;
	logic [7:0] exp_rx [5];
	logic [2:0] codes [5];
	int fail_count, check_count;

	// ------------------------------------------------------------
	// design, far end and clock
	// ------------------------------------------------------------
	spi_fifo_port DUT (.i_ref_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_spi_en(spi_en),
		.i_tx_en(tx_en), .i_rx_en(rx_en), .i_slave_mode(slave), .i_fifo_reset(fifo_rst),
		.i_word_len(wlen), .i_clk_div(div), .i_rx_threshold(rx_thr), .i_tx_threshold(tx_thr),
		.i_sclk(sclk_in), .i_cs_n(cs_n_in), .i_sdi(sdi_in), .o_sclk(sclk_out),
		.o_sclk_oe(sclk_oe), .o_sdo(sdo), .o_select_pin_a_n(sel_a_n),
		.o_select_pin_b_n(sel_b_n), .o_select_gpio_n(sel_g_n), .o_rx_overflow_flag(ovf),
		.o_rx_threshold_hit(rx_hit), .o_tx_threshold_hit(tx_hit));
	spi_far_end FAR (.i_sclk_m(sclk_out), .i_sdo(sdo), .i_sel_n(sel_a_n & sel_b_n & sel_g_n),
		.i_word_len(wlen), .i_reply(reply), .o_sclk(sclk_in), .o_cs_n(cs_n_in), .o_sdi(sdi_in));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// remembers which select output went low since last cleared
	always @(posedge clk) seen <= seen | {~sel_g_n, ~sel_b_n, ~sel_a_n};

	// ------------------------------------------------------------
	// expectations, compare and bus tasks
	// ------------------------------------------------------------
	function automatic logic [15:0] fstat(logic act, logic ov, int txl, int rxl);
		fstat = 16'h0000;
		fstat[spi_fifo_pkg::BIT_XFER_ACTIVE] = act;
		fstat[spi_fifo_pkg::BIT_RX_OVERFLOW] = ov;
		fstat[spi_fifo_pkg::BIT_TX_FULL] = (txl >= spi_fifo_pkg::FIFO_BYTES);
		fstat[spi_fifo_pkg::BIT_RX_EMPTY] = (rxl == 0);
		fstat[11:6] = txl[5:0];
		fstat[5:0] = rxl[5:0];
	endfunction : fstat
	function automatic logic [15:0] tstat(int rxl, int txl);
		tstat = 16'h0000;
		tstat[spi_fifo_pkg::BIT_RX_THRESH] = (rxl >= rx_thr + 1);
		tstat[spi_fifo_pkg::BIT_TX_THRESH] = (txl <= tx_thr);
	endfunction : tstat
	function automatic logic [2:0] sel_exp(logic [2:0] code);
		case (code)
			spi_fifo_pkg::SEL_PIN_A: sel_exp = 3'h1;
			spi_fifo_pkg::SEL_PIN_B: sel_exp = 3'h2;
			spi_fifo_pkg::SEL_GPIO: sel_exp = 3'h4;
			default: sel_exp = 3'h0;
		endcase
	endfunction : sel_exp
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, g, e);
		end
	endtask : chk
	task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [31:0] a, output logic [15:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		d = rdata;
		rd = 1'b0;
	endtask : rd_reg
	task automatic rd_chk(input logic [31:0] a, input logic [15:0] e, input string what);
		logic [15:0] d;
		rd_reg(a, d);
		chk({16'h0000, d}, {16'h0000, e}, what);
	endtask : rd_chk
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	// polls until a master transfer has started and ended, bounded
	task automatic xfer_wait();
		logic [15:0] s;
		logic act;
		act = 1'b0;
		for (int i = 0; i < 600; i++) begin
			rd_reg(spi_fifo_pkg::FIFO_STATUS_ADDR, s);
			if (s[spi_fifo_pkg::BIT_XFER_ACTIVE] === 1'b1) act = 1'b1;
			else if (act) break;
		end
		chk({30'h0, act, s[spi_fifo_pkg::BIT_XFER_ACTIVE]}, 32'h2, "active then idle");
		if (s[spi_fifo_pkg::BIT_XFER_ACTIVE] !== 1'b0) summarize();
		repeat (4) @(negedge clk);
	endtask : xfer_wait

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h6ED890EF;
		fail_count = 0;
		check_count = 0;
		{rst_n, wr, rd, spi_en, slave, fifo_rst, seen} = '0;
		{tx_en, rx_en} = 2'b11;
		addr = '0;
		wdata = '0;
		reply = '0;
		wlen = 5'h07;
		div = 7'h03;
		tmp = $random(seed);
		rx_thr = {2'b00, tmp[1:0]};
		tx_thr = {2'b00, tmp[3:2]};
		codes = '{spi_fifo_pkg::SEL_PIN_A, spi_fifo_pkg::SEL_PIN_B, spi_fifo_pkg::SEL_GPIO,
			spi_fifo_pkg::SEL_NONE, 3'h3};
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		// reset values and refused accesses
		chk({29'h0, ovf, rx_hit, tx_hit}, 32'h1, "status outputs after reset");
		rd_chk(spi_fifo_pkg::THRESHOLD_STATUS_ADDR, tstat(0, 0), "threshold reset");
		rd_chk(spi_fifo_pkg::FIFO_STATUS_ADDR, fstat(0, 0, 0, 0), "fifo status reset");
		rd_chk(spi_fifo_pkg::RX_DATA_PORT_ADDR, 16'h0000, "empty rx port");
		rd_chk(spi_fifo_pkg::HIGH_HALF_DATA_ADDR, 16'h0000, "high half reset");
		rd_chk(32'h5000_1234, 16'h0000, "unmapped read");
		// fill tx while the link is off, fifth write is refused
		for (int i = 1; i <= 5; i++) begin
			tmp = $random(seed);
			wr_reg(spi_fifo_pkg::TX_DATA_PORT_ADDR, tmp[15:0]);
			rd_chk(spi_fifo_pkg::FIFO_STATUS_ADDR, fstat(0, 0, (i > 4) ? 4 : i, 0), "tx fill");
			rd_chk(spi_fifo_pkg::THRESHOLD_STATUS_ADDR, tstat(0, (i > 4) ? 4 : i), "tx thr");
		end
		rd_chk(spi_fifo_pkg::TX_DATA_PORT_ADDR, 16'h0000, "tx port reads zero");
		fifo_rst = 1'b1;
		wr_reg(spi_fifo_pkg::TX_DATA_PORT_ADDR, 16'h00A5);
		fifo_rst = 1'b0;
		rd_chk(spi_fifo_pkg::FIFO_STATUS_ADDR, fstat(0, 0, 0, 0), "fifo reset empties");
		// master transfers, one per select code plus unused code 3; fifth overflows rx
		spi_en = 1'b1;
		FAR.got_q.delete();
		for (int i = 0; i < 5; i++) begin
			tmp = $random(seed);
			reply = {24'h0, tmp[23:16]};
			exp_rx[i] = tmp[23:16];
			wr_reg(spi_fifo_pkg::SELECT_CONFIG_ADDR, {13'h0, codes[i]});
			rd_chk(spi_fifo_pkg::SELECT_CONFIG_ADDR, {13'h0, codes[i]}, "select readback");
			seen = 3'b000;
			wr_reg(spi_fifo_pkg::TX_DATA_PORT_ADDR, {8'h00, tmp[7:0]});
			xfer_wait();
			chk({31'h0, sclk_oe}, 32'h1, "clock driven in master");
			chk({29'h0, seen}, {29'h0, sel_exp(codes[i])}, "select output");
			if (i < 3) chk(FAR.got_q.pop_front(), {24'h0, tmp[7:0]}, "word sent");
		end
		chk({31'h0, ovf}, 32'h1, "overflow output");
		rd_chk(spi_fifo_pkg::FIFO_STATUS_ADDR, fstat(0, 1, 0, 4), "rx full, overflow");
		rd_chk(spi_fifo_pkg::THRESHOLD_STATUS_ADDR, tstat(4, 0), "rx thr");
		chk({30'h0, rx_hit, tx_hit}, 32'h3, "threshold outputs");
		for (int i = 0; i < 3; i++)
			rd_chk(spi_fifo_pkg::RX_DATA_PORT_ADDR, {8'h00, exp_rx[i]}, "rx pop order");
		rd_reg(spi_fifo_pkg::RX_DATA_PORT_ADDR, hi);
		rd_chk(spi_fifo_pkg::FIFO_STATUS_ADDR, fstat(0, 1, 0, 0), "overflow sticky");
		fifo_rst = 1'b1;
		@(negedge clk);
		fifo_rst = 1'b0;
		rd_chk(spi_fifo_pkg::FIFO_STATUS_ADDR, fstat(0, 0, 0, 0), "overflow cleared");
		// 24 bit word through the high half register
		wlen = 5'h17;
		wr_reg(spi_fifo_pkg::SELECT_CONFIG_ADDR, {13'h0, spi_fifo_pkg::SEL_PIN_A});
		tmp = $random(seed);
		reply = {8'h00, tmp[31:8]};
		hi = tmp[15:0];
		wr_reg(spi_fifo_pkg::HIGH_HALF_DATA_ADDR, hi);
		tmp = $random(seed);
		wr_reg(spi_fifo_pkg::TX_DATA_PORT_ADDR, tmp[15:0]);
		xfer_wait();
		chk(FAR.got_q.pop_front(), {8'h00, hi[7:0], tmp[15:0]}, "wide word sent");
		rd_chk(spi_fifo_pkg::RX_DATA_PORT_ADDR, reply[15:0], "wide low half");
		rd_chk(spi_fifo_pkg::HIGH_HALF_DATA_ADDR, reply[31:16], "wide high half");
		// slave frame sourced from the preload buffer
		slave = 1'b1;
		wlen = 5'h1F;
		exp_w = $random(seed);
		wr_reg(spi_fifo_pkg::SHIFT_PRELOAD_LOW_ADDR, exp_w[15:0]);
		wr_reg(spi_fifo_pkg::SHIFT_PRELOAD_HIGH_ADDR, exp_w[31:16]);
		tmp = $random(seed);
		FAR.frame(tmp, 32, got);
		repeat (4) @(negedge clk);
		chk(got, exp_w, "preload shifted out");
		chk({31'h0, sclk_oe}, 32'h0, "clock released in slave");
		rd_chk(spi_fifo_pkg::RX_DATA_PORT_ADDR, tmp[15:0], "slave rx low");
		rd_chk(spi_fifo_pkg::HIGH_HALF_DATA_ADDR, tmp[31:16], "slave rx high");
		summarize();
	end
endmodule : tb
